// ---- cs_params.svh ----
// Purpose: Constants of the program sequencing core
// Assumes: Byte addresses on a 32-bit APB, 12 address bits decoded
// Notes:   Offsets, field positions, reset values, sizes and addresses only
`ifndef CS_PARAMS_SVH
`define CS_PARAMS_SVH

// ************************************************************
// Register map
// ************************************************************
`define CS_OFF_EXEC      12'h000
`define CS_OFF_PC        12'h004
`define CS_OFF_ASR       12'h008
`define CS_OFF_ACC       12'h00c
`define CS_OFF_CR0       12'h010
`define CS_OFF_TBL       12'h014
`define CS_OFF_ROMA      12'h018
`define CS_OFF_ROMD      12'h01c
`define CS_OFF_INSTR     12'h020
`define CS_OFF_RAM       12'h080
`define CS_RAM_SPAN      12'h07c

// ************************************************************
// Sizes and addresses
// ************************************************************
`define CS_PC_W          11
`define CS_ROM_W         10
`define CS_ROM_STEPS     2026
`define CS_TEST_FIRST    11'h7ea
`define CS_TEST_LAST     11'h7ff
`define CS_PC_RST        11'h000
`define CS_RAM_WORDS     32
`define CS_RAM_FIRST_LO  5'h00
`define CS_RAM_FIRST_HI  5'h01
`define CS_RAM_LAST_LO   5'h1e
`define CS_RAM_LAST_HI   5'h1f
`define CS_CR0_RST       8'h00
`define CS_NIB_ONES      4'hf

// ************************************************************
// Field positions
// ************************************************************
`define CS_EX_OP_LSB     0
`define CS_EX_LEN_BIT    4
`define CS_EX_IMM_LSB    8
`define CS_EX_DST_LSB    16
`define CS_CR0_DP_LSB    4
`define CS_PC_DEPTH_BIT  16
`define CS_ACC_CY_BIT    4
`define CS_TBL_DATA_LSB  16

`endif

// ---- cs_pkg.sv ----
// Purpose: Types of the program sequencing core
// Assumes: cs_params.svh is on the include path
// Notes:   Opcode codes are the EXEC register op field
`default_nettype none
package cs_pkg;

	// ************************************************************
	// Instruction codes
	// ************************************************************
	typedef enum logic [3:0] {
		CS_OP_NOP   = 4'h0,
		CS_OP_JMP   = 4'h1,
		CS_OP_JC    = 4'h2,
		CS_OP_JNC   = 4'h3,
		CS_OP_CALL  = 4'h4,
		CS_OP_RET   = 4'h5,
		CS_OP_TBLRD = 4'h6,
		CS_OP_MOV   = 4'h7,
		CS_OP_ANL   = 4'h8,
		CS_OP_ORL   = 4'h9,
		CS_OP_XRL   = 4'ha,
		CS_OP_RL    = 4'hb,
		CS_OP_RLZ   = 4'hc,
		CS_OP_INC   = 4'hd
	} cs_op_t;

endpackage

`default_nettype wire

// ---- cs_core.sv ----
// Purpose: Program sequencing core of a small 4-bit controller, APB slave
// Assumes: pclk 100 MHz, presetn asynchronous active low, APB3 master
// Notes:   Software issues one instruction per write to the EXEC register
//
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/100ps
`include "cs_params.svh"
`default_nettype none

module cs_core #(
	parameter int ROM_STEPS = `CS_ROM_STEPS
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	output var  logic        sys_reset_pulse
);

	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		logic [ROM_STEPS-1:0][`CS_ROM_W-1:0]    rom;
		logic [`CS_RAM_WORDS-1:0][3:0]          ram;
		logic [`CS_PC_W-1:0]                    pc;
		logic                                   depth;
		logic [2:0]                             asr_hi;
		logic [3:0]                             acc;
		logic                                   carry;
		logic [7:0]                             cr0;
		logic [`CS_PC_W-1:0]                    rom_addr;
		logic [`CS_ROM_W-1:0]                   tbl_data;
		logic                                   sysrst;
		logic [31:0]                            rdata;
		logic                                   slverr;
	} cs_state_t;

	cs_state_t s_q;
	cs_state_t s_d;

	// ************************************************************
	// Helpers
	// ************************************************************
	// Inside the mounted steps, below the test area
	function automatic logic in_rom(input logic [`CS_PC_W-1:0] a);
		in_rom = (32'(a) < ROM_STEPS) && (a < `CS_TEST_FIRST);
	endfunction

	function automatic logic [`CS_ROM_W-1:0] rom_word(
		input cs_state_t            s,
		input logic [`CS_PC_W-1:0]  a
	);
		rom_word = in_rom(a) ? s.rom[a] : '0;
	endfunction

	function automatic logic [`CS_PC_W-1:0] asr_of(input cs_state_t s);
		asr_of = {s.asr_hi, s.ram[`CS_RAM_LAST_HI],
			s.ram[`CS_RAM_LAST_LO]};
	endfunction

	function automatic logic [`CS_PC_W-1:0] dptr_of(input cs_state_t s);
		dptr_of = {s.cr0[`CS_CR0_DP_LSB+2:`CS_CR0_DP_LSB],
			s.ram[`CS_RAM_FIRST_HI], s.ram[`CS_RAM_FIRST_LO]};
	endfunction

	function automatic logic is_ram(input logic [11:0] a);
		is_ram = (a >= `CS_OFF_RAM) && (a <= `CS_OFF_RAM + `CS_RAM_SPAN)
			&& (a[1:0] == 2'b00);
	endfunction

	function automatic logic [4:0] ram_idx(input logic [11:0] a);
		ram_idx = 5'((a - `CS_OFF_RAM) >> 2);
	endfunction

	// Used only by the stack fault reset; pin reset loads its own fields in the register block
	function automatic cs_state_t sys_reset(input cs_state_t s);
		cs_state_t r;
		r = s;
		r.pc = `CS_PC_RST;
		r.depth = 1'b0;
		r.ram[`CS_RAM_FIRST_LO] = 4'h0;
		r.ram[`CS_RAM_FIRST_HI] = 4'h0;
		r.cr0 = `CS_CR0_RST;
		r.carry = 1'b0;
		r.tbl_data = '0;
		sys_reset = r;
	endfunction

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		cs_pkg::cs_op_t           op;
		logic [`CS_PC_W-1:0]      dest;
		logic [`CS_PC_W-1:0]      nxt;
		logic [3:0]               imm;
		logic [4:0]               ri;
		logic                     setup;
		logic                     wr;
		op = cs_pkg::cs_op_t'(pwdata[`CS_EX_OP_LSB+3:`CS_EX_OP_LSB]);
		dest = pwdata[`CS_EX_DST_LSB+`CS_PC_W-1:`CS_EX_DST_LSB];
		imm = pwdata[`CS_EX_IMM_LSB+3:`CS_EX_IMM_LSB];
		// Length one or two steps
		nxt = s_q.pc + (pwdata[`CS_EX_LEN_BIT] ? 11'h002 : 11'h001);
		ri = ram_idx(paddr);
		setup = psel && !penable;
		wr = psel && penable && pwrite;
		s_d = s_q;
		s_d.sysrst = 1'b0;

		// Read data is captured in setup so it leaves a flop
		if (setup) begin
			s_d.rdata = '0;
			s_d.slverr = 1'b0;
			if (!pwrite) begin
				case (paddr)
					`CS_OFF_EXEC: s_d.rdata = '0;
					`CS_OFF_PC: begin
						s_d.rdata[`CS_PC_W-1:0] = s_q.pc;
						s_d.rdata[`CS_PC_DEPTH_BIT] = s_q.depth;
					end
					`CS_OFF_ASR: s_d.rdata[`CS_PC_W-1:0] = asr_of(s_q);
					`CS_OFF_ACC: begin
						s_d.rdata[3:0] = s_q.acc;
						s_d.rdata[`CS_ACC_CY_BIT] = s_q.carry;
					end
					`CS_OFF_CR0: s_d.rdata[7:0] = s_q.cr0;
					`CS_OFF_TBL: begin
						s_d.rdata[`CS_PC_W-1:0] = dptr_of(s_q);
						s_d.rdata[`CS_TBL_DATA_LSB+`CS_ROM_W-1:
							`CS_TBL_DATA_LSB] = s_q.tbl_data;
					end
					`CS_OFF_ROMA: s_d.rdata[`CS_PC_W-1:0] = s_q.rom_addr;
					`CS_OFF_ROMD:
						s_d.rdata[`CS_ROM_W-1:0] = rom_word(s_q, s_q.rom_addr);
					`CS_OFF_INSTR:
						s_d.rdata[`CS_ROM_W-1:0] = rom_word(s_q, s_q.pc);
					default: begin
						if (is_ram(paddr)) begin
							s_d.rdata[3:0] = s_q.ram[ri];
							if (ri == `CS_RAM_LAST_LO || ri == `CS_RAM_LAST_HI)
								s_d.asr_hi = 3'h0;
						end else begin
							s_d.slverr = 1'b1;
						end
					end
				endcase
			end else begin
				// Writes: only the read-only and unmapped words are refused
				case (paddr)
					`CS_OFF_EXEC, `CS_OFF_ACC, `CS_OFF_CR0, `CS_OFF_ROMA,
					`CS_OFF_ROMD: s_d.slverr = 1'b0;
					default: s_d.slverr = !is_ram(paddr);
				endcase
			end
		end

		// Writes take effect at the access edge
		if (wr) begin
			case (paddr)
				`CS_OFF_EXEC: begin
					if (!in_rom(s_q.pc)) begin
						s_d.pc = `CS_PC_RST;
					end else begin
						s_d.pc = nxt;
						case (op)
							cs_pkg::CS_OP_NOP: s_d.pc = nxt;
							cs_pkg::CS_OP_JMP: s_d.pc = dest;
							cs_pkg::CS_OP_JC:
								if (s_q.carry)
									s_d.pc = dest;
							cs_pkg::CS_OP_JNC:
								if (!s_q.carry)
									s_d.pc = dest;
							cs_pkg::CS_OP_CALL: begin
								if (s_q.depth) begin
									s_d = sys_reset(s_d);
									s_d.sysrst = 1'b1;
								end else begin
									s_d.ram[`CS_RAM_LAST_LO] = nxt[3:0];
									s_d.ram[`CS_RAM_LAST_HI] = nxt[7:4];
									s_d.asr_hi = nxt[10:8];
									s_d.depth = 1'b1;
									s_d.pc = dest;
								end
							end
							cs_pkg::CS_OP_RET: begin
								if (!s_q.depth) begin
									s_d = sys_reset(s_d);
									s_d.sysrst = 1'b1;
								end else begin
									s_d.pc = asr_of(s_q);
									s_d.depth = 1'b0;
								end
							end
							cs_pkg::CS_OP_TBLRD: begin
								if (in_rom(dptr_of(s_q)))
									s_d.tbl_data = s_q.rom[dptr_of(s_q)];
								else
									s_d.pc = `CS_PC_RST;
							end
							cs_pkg::CS_OP_MOV: begin
								s_d.acc = imm;
								s_d.carry = 1'b0;
							end
							cs_pkg::CS_OP_ANL: begin
								s_d.acc = s_q.acc & imm;
								s_d.carry = s_q.acc[3] & imm[3];
							end
							cs_pkg::CS_OP_ORL: begin
								s_d.acc = s_q.acc | imm;
								s_d.carry = 1'b0;
							end
							cs_pkg::CS_OP_XRL: begin
								s_d.acc = s_q.acc ^ imm;
								s_d.carry = s_q.acc[3] & imm[3];
							end
							cs_pkg::CS_OP_RL: begin
								s_d.acc = {s_q.acc[2:0], s_q.acc[3]};
								s_d.carry = s_q.acc[3];
							end
							cs_pkg::CS_OP_RLZ: begin
								s_d.acc = {s_q.acc[2:0], 1'b0};
								s_d.carry = s_q.acc[3];
							end
							cs_pkg::CS_OP_INC: begin
								s_d.acc = s_q.acc + 4'h1;
								s_d.carry = (s_q.acc == `CS_NIB_ONES);
							end
							default: s_d.pc = nxt;
						endcase
					end
				end
				`CS_OFF_ACC: s_d.acc = pwdata[3:0];
				// Depth bit has no direct register write; only CALL and RET through EXEC change it
				`CS_OFF_CR0: s_d.cr0 = pwdata[7:0];
				`CS_OFF_ROMA: s_d.rom_addr = pwdata[`CS_PC_W-1:0];
				`CS_OFF_ROMD: begin
					// Loads into the test area are dropped
					if (in_rom(s_q.rom_addr))
						s_d.rom[s_q.rom_addr] = pwdata[`CS_ROM_W-1:0];
					s_d.rom_addr = s_q.rom_addr + 11'h001;
				end
				default: begin
					if (is_ram(paddr)) begin
						s_d.ram[ri] = pwdata[3:0];
						if (ri == `CS_RAM_LAST_LO || ri == `CS_RAM_LAST_HI)
							s_d.asr_hi = 3'h0;
					end
				end
			endcase
		end
	end

	// ************************************************************
	// Registers
	// ************************************************************
	// ROM, most RAM, accumulator and saved high bits keep their value
	// through reset, so reset touches only the fields below
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q.pc <= `CS_PC_RST;
			s_q.depth <= 1'b0;
			s_q.ram[`CS_RAM_FIRST_LO] <= 4'h0;
			s_q.ram[`CS_RAM_FIRST_HI] <= 4'h0;
			s_q.cr0 <= `CS_CR0_RST;
			s_q.carry <= 1'b0;
			s_q.rom_addr <= '0;
			s_q.tbl_data <= '0;
			s_q.sysrst <= 1'b0;
			s_q.rdata <= '0;
			s_q.slverr <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign prdata = s_q.rdata;
	assign pslverr = s_q.slverr && psel && penable;
	assign pready = 1'b1;
	assign sys_reset_pulse = s_q.sysrst;

endmodule

`default_nettype wire

// ---- cs_core_asserts.sv ----
// Purpose: Port checks of the sequencing core
// Assumes: One-cycle APB access with pready high
// Notes:   Attached to every cs_core by bind
`timescale 1ns/100ps
`include "cs_params.svh"
`default_nettype none
module cs_core_asserts (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        sys_reset_pulse
);
	// ****
	// Access decode
	// ****
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	wire logic rd = psel && penable && !pwrite;
	wire logic wr = psel && penable && pwrite;
	wire logic ex = wr && paddr == `CS_OFF_EXEC;
	wire logic ram = paddr >= `CS_OFF_RAM && paddr[11:8] == 4'h0;
	// ****
	// Properties
	// ****
	pc_width_a: assert property (rd && paddr == `CS_OFF_PC |->
		prdata[31:17] == '0 && prdata[15:11] == '0) else $error("pc width");
	depth_ro_a: assert property (wr && paddr == `CS_OFF_PC |->
		pslverr) else $error("pc write taken");
	asr_ro_a: assert property (wr && paddr == `CS_OFF_ASR |->
		pslverr) else $error("asr write taken");
	asr_width_a: assert property (rd && paddr == `CS_OFF_ASR |->
		prdata[31:11] == '0) else $error("asr width");
	tbl_ro_a: assert property (wr && paddr == `CS_OFF_TBL |-> pslverr)
		else $error("pointer write taken");
	rom_word_a: assert property (rd && paddr == `CS_OFF_INSTR |->
		prdata[31:10] == '0) else $error("rom width");
	ram_nib_a: assert property (rd && ram |-> prdata[31:4] == '0)
		else $error("ram width");
	pulse_once_a: assert property (sys_reset_pulse |=>
		!sys_reset_pulse) else $error("pulse too long");
	pulse_cause_a: assert property ($rose(sys_reset_pulse) |->
		$past(ex && pwdata[3:1] == 3'h2)) else $error("pulse cause");
	cover property (ex && pwdata[3:0] == 4'h4);
	cover property (sys_reset_pulse);
	cover property (rd && pslverr);
endmodule
bind cs_core cs_core_asserts chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.sys_reset_pulse(sys_reset_pulse));
`default_nettype wire

// ---- tb.sv ----
// Purpose: Self-checking bench of the sequencing core
// Assumes: Integer model of counter, stack, ram, rom and alu
// Notes:   Registers reached over APB only
`timescale 1ns/100ps
`include "cs_params.svh"
`default_nettype none
module tb;
	logic        pclk = 0;
	logic        presetn, psel, penable, pwrite, pready, pslverr, srp, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	int          mismatches = 0;
	int          checked = 0;
	int          pc, dep, ahi, acc, cy, cr0, tbl, ram[32], rom[2048];
	always #5 pclk = ~pclk;
	cs_core dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sys_reset_pulse(srp));
	// ****
	// Checks and bus
	// ****
	task automatic wrap_up();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk_word(input logic [31:0] g, x, input string m);
		checked++;
		if (g !== x) begin
			mismatches++;
			$display("unexpected %0t: %s %h/%h", $time, m, g, x);
		end
	endtask
	task automatic chk_err(input logic g, x, input string m);
		checked++;
		if (g !== x) begin
			mismatches++;
			$display("unexpected %0t: %s error flag", $time, m);
		end
	endtask
	task automatic chk_pulse(input logic g, x);
		checked++;
		if (g !== x) begin
			mismatches++;
			$display("unexpected %0t: reset pulse %b", $time, g);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		// Only the watchdog ends a wait that never sees pready
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d,
		input logic x);
		apb(1, a, d);
		chk_err(e, x, "write");
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] x);
		apb(0, a, 0);
		chk_err(e, 0, "read");
		chk_word(r, x, "read");
	endtask
	// ****
	// Model
	// ****
	function automatic int return_address_save();
		return ahi << 8 | ram[31] << 4 | ram[30];
	endfunction
	task automatic mres();
		pc = 0;
		dep = 0;
		ram[0] = 0;
		ram[1] = 0;
		cr0 = 0;
		cy = 0;
		tbl = 0;
	endtask
	task automatic rw(input int i, d);
		ram[i] = d;
		if (i >= 30)
			ahi = 0;
		wr(12'(`CS_OFF_RAM + 4 * i), d, 0);
	endtask
	task automatic rr(input int i);
		if (i >= 30)
			ahi = 0;
		rd(12'(`CS_OFF_RAM + 4 * i), ram[i]);
	endtask
	task automatic ex(input int op, ln, im, ds);
		int nx;
		int p;
		nx = pc + ln + 1;
		p = (cr0 >> 4 & 7) << 8 | ram[1] << 4 | ram[0];
		wr(`CS_OFF_EXEC, ds << 16 | im << 8 | ln << 4 | op, 0);
		if (pc >= `CS_ROM_STEPS)
			nx = 0;
		else case (op)
			1: nx = ds;
			2: nx = cy ? ds : nx;
			3: nx = cy ? nx : ds;
			4: if (dep) nx = -1;
			else begin
				ahi = nx >> 8;
				ram[31] = nx >> 4 & 15;
				ram[30] = nx & 15;
				dep = 1;
				nx = ds;
			end
			5: if (!dep) nx = -1;
			else begin
				nx = return_address_save();
				dep = 0;
			end
			6: if (p >= `CS_ROM_STEPS) nx = 0;
			else tbl = rom[p];
			7, 9: begin
				acc = op == 7 ? im : acc | im;
				cy = 0;
			end
			8, 10: begin
				cy = (acc & im) >> 3;
				acc = op == 8 ? acc & im : acc ^ im;
			end
			11, 12: begin
				cy = acc >> 3;
				acc = (acc << 1 | (op == 11 ? acc >> 3 : 0)) & 15;
			end
			13: begin
				cy = acc == 15;
				acc = (acc + 1) & 15;
			end
			default: ;
		endcase
		// Pulse flop is loaded at the access edge, so look just after it
		#1;
		chk_pulse(srp, nx < 0);
		if (nx < 0)
			mres();
		else
			pc = nx & 'h7ff;
		rd(`CS_OFF_PC, dep << 16 | pc);
	endtask
	// ****
	// Tests
	// ****
	initial begin
		#300000;
		mismatches++;
		$display("unexpected %0t: watchdog", $time);
		wrap_up();
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		void'($urandom(32'h7aec0d21));
		mres();
		repeat (12) @(posedge pclk);
		presetn <= 1;
		rd(`CS_OFF_PC, 0);
		rd(`CS_OFF_TBL, 0);
		rr(0);
		rr(1);
		wr(`CS_OFF_ROMA, 0, 0);
		for (int i = 0; i < 16; i++) begin
			rom[i] = $urandom & 'h3ff;
			wr(`CS_OFF_ROMD, rom[i], 0);
		end
		rd(`CS_OFF_ROMA, 16);
		wr(`CS_OFF_ROMA, 'h7ea, 0);
		wr(`CS_OFF_ROMD, 'h155, 0);
		wr(`CS_OFF_ROMA, 'h7ea, 0);
		rd(`CS_OFF_ROMD, 0);
		for (int i = 0; i < 16; i++) begin
			ex(1, 0, 0, 15 - i);
			rd(`CS_OFF_INSTR, rom[pc]);
		end
		$display("test reset and rom done");
		ex(0, 0, 0, 0);
		ex(0, 1, 0, 0);
		ex(15, 0, 0, 0);
		ex(1, 0, 0, 'h300);
		ex(4, 1, 0, 'h40);
		rd(`CS_OFF_ASR, return_address_save());
		@(posedge pclk);
		presetn <= 0;
		repeat (3) @(posedge pclk);
		presetn <= 1;
		mres();
		rd(`CS_OFF_ASR, return_address_save());
		ex(4, 0, 0, 'h50);
		ex(5, 0, 0, 0);
		rd(`CS_OFF_ASR, return_address_save());
		ex(5, 0, 0, 0);
		ex(4, 0, 0, 'h60);
		ex(4, 0, 0, 'h70);
		wr(`CS_OFF_PC, 'h10005, 1);
		wr(`CS_OFF_ASR, 'h123, 1);
		wr(`CS_OFF_TBL, 'h7ff, 1);
		rd(`CS_OFF_PC, 0);
		ex(1, 0, 0, 'h200);
		ex(4, 0, 0, 'h10);
		rr(30);
		rd(`CS_OFF_ASR, return_address_save());
		rw(31, 'ha);
		rd(`CS_OFF_ASR, return_address_save());
		ex(5, 0, 0, 0);
		for (int i = 0; i < 32; i++)
			rw(i, $urandom & 15);
		for (int i = 0; i < 32; i++)
			rr(i);
		$display("test stack and ram done");
		for (int i = 0; i < 4; i++) begin
			rw(0, $urandom & 15);
			rw(1, 0);
			cr0 = $urandom & 'h8f;
			wr(`CS_OFF_CR0, cr0, 0);
			ex(6, 0, 0, 0);
			rd(`CS_OFF_TBL, tbl << 16 | ram[0]);
		end
		rw(0, 15);
		rw(1, 15);
		cr0 = 'h70;
		wr(`CS_OFF_CR0, cr0, 0);
		rd(`CS_OFF_TBL, tbl << 16 | 'h7ff);
		ex(6, 0, 0, 0);
		ex(1, 0, 0, 'h7f0);
		ex(0, 0, 0, 0);
		apb(0, 12'h100, 0);
		chk_err(e, 1, "unmapped");
		$display("test table done");
		for (int k = 0; k < 42; k++) begin
			acc = k < 7 ? 15 : $urandom & 15;
			wr(`CS_OFF_ACC, acc, 0);
			ex(7 + k % 7, 0, $urandom & 15, 0);
			rd(`CS_OFF_ACC, cy << 4 | acc);
			ex(2 + k % 2, 0, 0, $urandom & 'h3ff);
		end
		$display("test alu done");
		wrap_up();
	end
endmodule
`default_nettype wire
